// ### rtl/touch_block_pkg.sv
// Notes on behaviour
// - blocking enable bit set turns on touch limiting; cleared, only a pattern event blocks touches.
// - with blocking on, accept new touches only up to the limit; keep accepted pads until released, even past a lowered limit.
// - after a release, pick reported touches in input order 1 to 8, block rest.
// - limit field bits 3:2 decode 00..11 to one..four touches; reset one.
// - pattern threshold is 12.5, 25, 37.5 or 100 percent of active or standby threshold.
// - pattern mode sets event when every selected input is above threshold or noisy.
// - count mode sets event when qualifying inputs reach the number of selected bits.
// - evaluate the match once per sensing cycle from that cycle's deltas and noise flags.
// - on a pattern event block all touch reporting and raise an interrupt if enabled.
// - keep all inputs blocked while the condition persists; restore when it ends.
// - pattern event status clears only by host write of one to bit 0 at 44h after condition ends.
// - pattern detection runs only while pattern enable bit 7 is one; resets off.
// - alert output asserts only if pattern alert enable bit 0 set; status always set.
// - compare mode bit 1 selects count mode at zero, pattern mode at one.
// - select bit n-1 maps to input n; resets to all ones.
// - read-only base flag register at 2Eh; any flag sets the summary bit.
// - a base flag reads one when that base count is outside its range.
package touch_block_pkg;
   localparam int          N_INPUTS         = 8;
   localparam int          DELTA_W          = 8;
   localparam int          ADDR_W           = 8;
   // register byte addresses
   localparam logic [7:0] ADDR_MT_CFG      = 8'h2a;
   localparam logic [7:0] ADDR_PAT_CFG     = 8'h2b;
   localparam logic [7:0] ADDR_PAT_SEL     = 8'h2d;
   localparam logic [7:0] ADDR_BASE_FLAGS  = 8'h2e;
   localparam logic [7:0] ADDR_STATUS      = 8'h40;
   localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h44;
   localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h48;
   // reset values
   localparam logic [7:0] RST_MT_CFG       = 8'h80;
   localparam logic [7:0] RST_PAT_CFG      = 8'h00;
   localparam logic [7:0] RST_PAT_SEL      = 8'hff;
   localparam logic [2:0] RST_IRQ_ENABLE   = 3'h0;
   // field positions
   localparam int          BIT_BLOCK_EN     = 7;
   localparam int          BIT_MT_FIXED     = 6;
   localparam int          LIM_LO           = 2;
   localparam int          BIT_PAT_EN       = 7;
   localparam int          THR_LO           = 2;
   localparam int          BIT_COMP_MODE    = 1;
   localparam int          BIT_PAT_ALERT    = 0;
   // status bit positions
   localparam int          ST_PATTERN       = 0;
   localparam int          ST_OVERFLOW      = 1;
   localparam int          ST_BASE          = 2;
   localparam int          N_STATUS         = 3;
   // threshold fractions in eighths
   localparam logic [3:0] FRAC_12P5        = 4'h1;
   localparam logic [3:0] FRAC_25          = 4'h2;
   localparam logic [3:0] FRAC_37P5        = 4'h3;
   localparam logic [3:0] FRAC_100         = 4'h8;
   localparam int          FRAC_SHIFT       = 3;

   typedef struct packed {
      logic [N_INPUTS-1:0]          touch;      // raw touch detect
      logic [N_INPUTS-1:0]          noise;      // noise flags
      logic [N_INPUTS-1:0]          standby;    // input sensed in standby
      logic [N_INPUTS-1:0]          base_out;   // base count out of range
      logic [N_INPUTS*DELTA_W-1:0]  delta;      // delta counts
      logic [N_INPUTS*DELTA_W-1:0]  thr_act;    // active thresholds
      logic [N_INPUTS*DELTA_W-1:0]  thr_sby;    // standby thresholds
   } sense_t;
endpackage

// ### rtl/touch_block.sv
`timescale 1ns/1ps
module touch_block #(
   parameter int N = touch_block_pkg::N_INPUTS
) (
   input  wire logic                       clk,              // 100 MHz clock
   input  wire logic                       nrst,             // async reset, low
   input  wire logic                       cycle_done,       // one pulse per sensing cycle
   input  wire touch_block_pkg::sense_t    sense,            // front-end data
   input  wire logic [7:0]                 avs_address,      // byte address
   input  wire logic                       avs_read,         // read strobe
   input  wire logic                       avs_write,        // write strobe
   input  wire logic [31:0]                avs_writedata,    // write data
   output logic [31:0]                     avs_readdata,     // read data
   output logic                            avs_waitrequest,  // stall
   output logic [N-1:0]                    touch_report,     // reported touches
   output logic                            irq,              // interrupt, high
   output logic                            alert_n           // alert pin, low
);
   localparam int DW = touch_block_pkg::DELTA_W;

   logic [7:0]                        mt_cfg_q;
   logic [7:0]                        pat_cfg_q;
   logic [7:0]                        pat_sel_q;
   logic [N-1:0]                      base_q;
   logic [touch_block_pkg::N_STATUS-1:0] status_q;
   logic [touch_block_pkg::N_STATUS-1:0] irq_en_q;
   logic [N-1:0]                      accepted_q;
   logic                              cond_q;
   logic                              alert_q;
   logic                              ack_q;
   logic [31:0]                       rdata_q;
   logic [N-1:0]                      qualify;
   logic                              cond_d;
   logic [N-1:0]                      accept_d;
   logic                              overflow_d;
   logic [3:0]                        frac;
   logic [3:0]                        limit;
   logic                              wr_take;
   logic                              rd_take;

   // count ones in an input vector
   function automatic logic [3:0] popcount(input logic [N-1:0] v);
      logic [3:0] c;
      c = '0;
      for (int i = 0; i < N; i++) begin
         c = c + 4'(v[i]);
      end
      return c;
   endfunction

   // single-cycle wait state keeps read data registered; a write lands
   // only at the edge where the stall is already low
   assign wr_take         = avs_write & ack_q;
   assign rd_take         = avs_read & ~ack_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = rdata_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // threshold fraction decode
   always_comb begin
      unique case (pat_cfg_q[touch_block_pkg::THR_LO +: 2])
         2'b00: frac = touch_block_pkg::FRAC_12P5;
         2'b01: frac = touch_block_pkg::FRAC_25;
         2'b10: frac = touch_block_pkg::FRAC_37P5;
         2'b11: frac = touch_block_pkg::FRAC_100;
      endcase
   end

   // qualifying inputs: delta above scaled threshold or noisy
   generate
      for (genvar g = 0; g < N; g++) begin : g_qual
         logic [DW-1:0]   thr;
         logic [DW+3:0]   scaled;
         assign thr     = sense.standby[g] ? sense.thr_sby[g*DW +: DW] : sense.thr_act[g*DW +: DW];
         assign scaled  = ({4'h0, thr} * {{DW{1'b0}}, frac}) >> touch_block_pkg::FRAC_SHIFT;
         assign qualify[g] = ({4'h0, sense.delta[g*DW +: DW]} > scaled) | sense.noise[g];
      end
   endgenerate

   // pattern or count match
   always_comb begin
      if (pat_cfg_q[touch_block_pkg::BIT_COMP_MODE]) begin
         cond_d = ((qualify & pat_sel_q) == pat_sel_q);
      end else begin
         cond_d = popcount(qualify) >= popcount(pat_sel_q);
      end
      cond_d = cond_d & pat_cfg_q[touch_block_pkg::BIT_PAT_EN];
   end

   // acceptance in input order, keeping earlier accepted pads
   assign limit = 4'(mt_cfg_q[touch_block_pkg::LIM_LO +: 2]) + 4'h1;
   always_comb begin
      logic [3:0] n;
      n          = '0;
      accept_d   = '0;
      overflow_d = 1'b0;
      // held pads first, they stay until released
      for (int i = 0; i < N; i++) begin
         if (sense.touch[i] && accepted_q[i]) begin
            accept_d[i] = 1'b1;
            n = n + 4'h1;
         end
      end
      for (int i = 0; i < N; i++) begin
         if (sense.touch[i] && !accepted_q[i]) begin
            if (n < limit) begin
               accept_d[i] = 1'b1;
               n = n + 4'h1;
            end else begin
               overflow_d = 1'b1;
            end
         end
      end
      if (!mt_cfg_q[touch_block_pkg::BIT_BLOCK_EN]) begin
         accept_d   = sense.touch;
         overflow_d = 1'b0;
      end
   end

   // per-cycle evaluation and reporting
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accepted_q   <= '0;
         cond_q       <= 1'b0;
         touch_report <= '0;
         base_q       <= '0;
      end else if (cycle_done) begin
         cond_q <= cond_d;
         base_q <= sense.base_out;
         if (cond_d) begin
            accepted_q   <= '0;
            touch_report <= '0;
         end else begin
            accepted_q   <= accept_d;
            touch_report <= accept_d;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mt_cfg_q  <= touch_block_pkg::RST_MT_CFG;
         pat_cfg_q <= touch_block_pkg::RST_PAT_CFG;
         pat_sel_q <= touch_block_pkg::RST_PAT_SEL;
         irq_en_q  <= touch_block_pkg::RST_IRQ_ENABLE;
      end else if (wr_take) begin
         unique case (avs_address)
            touch_block_pkg::ADDR_MT_CFG: begin
               mt_cfg_q <= (avs_writedata[7:0] & 8'h8c) | 8'h40;
            end
            touch_block_pkg::ADDR_PAT_CFG: begin
               pat_cfg_q <= avs_writedata[7:0] & 8'h8f;
            end
            touch_block_pkg::ADDR_PAT_SEL: begin
               pat_sel_q <= avs_writedata[7:0];
            end
            touch_block_pkg::ADDR_IRQ_ENABLE: begin
               irq_en_q <= avs_writedata[touch_block_pkg::N_STATUS-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= '0;
      end else begin
         logic [touch_block_pkg::N_STATUS-1:0] clr;
         logic [touch_block_pkg::N_STATUS-1:0] set;
         clr = '0;
         set = '0;
         if (wr_take && avs_address == touch_block_pkg::ADDR_IRQ_CLEAR) begin
            clr = avs_writedata[touch_block_pkg::N_STATUS-1:0];
         end
         // pattern flag cannot clear while its condition holds
         if (cond_q) begin
            clr[touch_block_pkg::ST_PATTERN] = 1'b0;
         end
         if (cycle_done) begin
            set[touch_block_pkg::ST_PATTERN]  = cond_d;
            set[touch_block_pkg::ST_OVERFLOW] = overflow_d & ~cond_d;
            set[touch_block_pkg::ST_BASE]     = |sense.base_out;
         end
         status_q <= (status_q & ~clr) | set;
      end
   end

   // alert follows pattern status only when alert enabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= status_q[touch_block_pkg::ST_PATTERN] & pat_cfg_q[touch_block_pkg::BIT_PAT_ALERT];
      end
   end
   assign alert_n = ~alert_q;
   assign irq     = |(status_q & irq_en_q);

   // registered read data; unmapped reads zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (rd_take) begin
         unique case (avs_address)
            touch_block_pkg::ADDR_MT_CFG:     rdata_q <= {24'h00_0000, mt_cfg_q | (8'h01 << touch_block_pkg::BIT_MT_FIXED)};
            touch_block_pkg::ADDR_PAT_CFG:    rdata_q <= {24'h00_0000, pat_cfg_q};
            touch_block_pkg::ADDR_PAT_SEL:    rdata_q <= {24'h00_0000, pat_sel_q};
            touch_block_pkg::ADDR_BASE_FLAGS: rdata_q <= {24'h00_0000, base_q};
            touch_block_pkg::ADDR_STATUS:     rdata_q <= {29'h0000_0000, status_q};
            touch_block_pkg::ADDR_IRQ_ENABLE: rdata_q <= {29'h0000_0000, irq_en_q};
            default:                          rdata_q <= '0;
         endcase
      end
   end
endmodule

// ### dv/touch_front_end.sv
`timescale 1ns/1ps
// front end: new sample every 16 clocks, held steady between pulses
module touch_front_end (
   input  wire logic                    clk,        // clock
   input  wire logic                    nrst,       // reset, low
   input  wire touch_block_pkg::sense_t nxt,        // next sample
   output touch_block_pkg::sense_t      sense,      // held sample
   output logic                         cycle_done  // end of cycle
);
   logic [3:0] cnt_q;
   // sample and pulse move together so the block never sees a half update
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q      <= 4'h0;
         cycle_done <= 1'b0;
         sense      <= '0;
      end else begin
         cnt_q      <= cnt_q + 4'h1;
         cycle_done <= (cnt_q == 4'hf);
         if (cnt_q == 4'hf) sense <= nxt;
      end
   end
endmodule

// ### dv/touch_block_checker.sv
`timescale 1ns/1ps
module touch_block_checker #(
   parameter int N = 8
) (
   input wire logic                    clk,             // clock
   input wire logic                    nrst,            // reset, low
   input wire logic                    cycle_done,      // cycle end
   input wire touch_block_pkg::sense_t sense,           // front end
   input wire logic [7:0]              avs_address,     // address
   input wire logic                    avs_read,        // read
   input wire logic                    avs_write,       // write
   input wire logic [31:0]             avs_writedata,   // write data
   input wire logic                    avs_waitrequest, // stall
   input wire logic [N-1:0]            touch_report,    // reported
   input wire logic                    alert_n          // alert, low
);
   logic [7:0] mt_q;
   logic [7:0] pat_q;
   // shadow of both config bytes as last accepted on the bus
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mt_q  <= 8'h80;
         pat_q <= 8'h00;
      end else if (avs_write && !avs_waitrequest && avs_address == 8'h2a) begin
         mt_q <= avs_writedata[7:0];
      end else if (avs_write && !avs_waitrequest && avs_address == 8'h2b) begin
         pat_q <= avs_writedata[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("stall too long");
   property p_subset; cycle_done |=> (touch_report & ~$past(sense.touch)) == '0; endproperty
   a_subset: assert property (p_subset) else $error("untouched input reported");
   property p_limit; cycle_done && mt_q[7] |=> $countones(touch_report) <= $past(mt_q[3:2]) + 1; endproperty
   a_limit: assert property (p_limit) else $error("too many touches");
   property p_noblock; cycle_done && !mt_q[7] && !pat_q[7] |=> touch_report == $past(sense.touch); endproperty
   a_noblock: assert property (p_noblock) else $error("touch blocked");
   property p_per_cycle; !$past(cycle_done) |-> $stable(touch_report); endproperty
   a_per_cycle: assert property (p_per_cycle) else $error("report moved");
   property p_evt_block; $fell(alert_n) && $past(pat_q[0], 3) && !$past(cycle_done) |-> touch_report == '0; endproperty
   a_evt_block: assert property (p_evt_block) else $error("event not blocking");
   property p_alert_en; !alert_n |-> $past(pat_q[0]); endproperty
   a_alert_en: assert property (p_alert_en) else $error("alert not enabled");
   property p_no_self; $rose(alert_n) |-> $past(avs_write) || $past(avs_write, 2); endproperty
   a_no_self: assert property (p_no_self) else $error("alert self cleared");
endmodule
bind touch_block touch_block_checker #(.N(N)) i_touch_block_checker (
   .clk(clk), .nrst(nrst), .cycle_done(cycle_done), .sense(sense), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .touch_report(touch_report), .alert_n(alert_n));

// ### dv/touch_block_tb.sv
`timescale 1ns/1ps
module touch_block_tb;
   logic                    clk = 1'b0;
   logic                    nrst = 1'b0;
   logic [7:0]              avs_address = 8'h00;
   logic                    avs_read = 1'b0;
   logic                    avs_write = 1'b0;
   logic [31:0]             avs_writedata = 32'h0000_0000;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   logic [7:0]              touch_report;
   logic                    irq;
   logic                    alert_n;
   logic                    cycle_done;
   touch_block_pkg::sense_t sense;
   touch_block_pkg::sense_t nxt = '0;
   int                      n_mismatch = 0;
   int                      check_count = 0;
   int                      fr[4] = '{1, 2, 3, 8};
   logic [7:0]              q;
   always #5 clk = ~clk;
   touch_front_end i_touch_front_end (.clk(clk), .nrst(nrst), .nxt(nxt), .sense(sense), .cycle_done(cycle_done));
   touch_block i_touch_block (.clk(clk), .nrst(nrst), .cycle_done(cycle_done), .sense(sense),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .touch_report(touch_report),
      .irq(irq), .alert_n(alert_n));
   task automatic finish_test();
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one bus transfer; request held until stall drops, then released
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0000_00, d};
      avs_write <= w;
      avs_read <= ~w;
      // stall is read before the edge's own updates land, as the slave sees it
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   // two cycle_done pulses so the new sample is surely evaluated
   task automatic step(input logic [7:0] t);
      nxt.touch = t;
      repeat (2) @(posedge cycle_done);
      repeat (4) @(negedge clk);
   endtask
   initial begin
      repeat (10000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      nxt.thr_act = {8{8'h40}};
      nxt.thr_sby = {8{8'h20}};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h2a, 8'hc0);
      rd(8'h2b, 8'h00);
      rd(8'h2d, 8'hff);
      acc(1'b1, 8'h2e, 8'hff);
      rd(8'h2e, 8'h00);
      rd(8'h10, 8'h00);
      acc(1'b1, 8'h2a, 8'h3f);
      rd(8'h2a, 8'h4c);
      acc(1'b1, 8'h2a, 8'h80);
      step(8'h06);
      chk(touch_report, 8'h02);
      step(8'h07);
      chk(touch_report, 8'h02);
      step(8'h05);
      chk(touch_report, 8'h01);
      rd(touch_block_pkg::ADDR_STATUS, 8'h02);
      // limit codes grow so earlier accepted pads stay inside the limit
      for (int l = 1; l < 4; l++) begin
         acc(1'b1, 8'h2a, 8'h80 | 8'(l << 2));
         step(8'hff);
         chk(touch_report, 8'((1 << (l + 1)) - 1));
      end
      acc(1'b1, 8'h2a, 8'h00);
      step(8'hff);
      chk(touch_report, 8'hff);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_CLEAR, 8'h07);
      acc(1'b1, 8'h2d, 8'h01);
      // blocked report shows the condition; edge value must not qualify
      for (int t = 0; t < 4; t++) begin
         acc(1'b1, 8'h2b, 8'h80 | 8'(t << 2));
         nxt.delta[7:0] = 8'(8 * fr[t]);
         step(8'h01);
         chk(touch_report, 8'h01);
         nxt.delta[7:0] = 8'(8 * fr[t] + 1);
         step(8'h01);
         chk(touch_report, 8'h00);
      end
      nxt.standby[0] = 1'b1;
      nxt.delta[7:0] = 8'h21;
      step(8'h01);
      chk(touch_report, 8'h00);
      nxt.touch = 8'h01;
      nxt.noise = 8'h01;
      nxt.delta = '0;
      nxt.standby = '0;
      nxt.base_out = '0;
      step(8'h01);
      chk(touch_report, 8'h00);
      nxt.noise = 8'h00;
      acc(1'b1, 8'h2d, 8'h05);
      acc(1'b1, 8'h2b, 8'h83);
      nxt.delta[7:0] = 8'h09;
      step(8'h01);
      chk(touch_report, 8'h01);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_CLEAR, 8'h07);
      repeat (2) @(negedge clk);
      chk(alert_n, 8'h01);
      nxt.noise[2] = 1'b1;
      step(8'h01);
      chk(touch_report, 8'h00);
      chk(alert_n, 8'h00);
      rd(touch_block_pkg::ADDR_STATUS, 8'h01);
      nxt.noise[2] = 1'b0;
      nxt.delta[55:48] = 8'h09;
      acc(1'b1, 8'h2b, 8'h81);
      step(8'h01);
      chk(touch_report, 8'h00);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_CLEAR, 8'h01);
      nxt.delta = '0;
      step(8'h01);
      chk(touch_report, 8'h01);
      chk(alert_n, 8'h00);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_ENABLE, 8'h01);
      chk(irq, 8'h01);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_ENABLE, 8'h00);
      chk(irq, 8'h00);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_ENABLE, 8'h01);
      acc(1'b1, touch_block_pkg::ADDR_IRQ_CLEAR, 8'h01);
      repeat (2) @(negedge clk);
      chk({irq, alert_n}, 8'h01);
      acc(1'b1, 8'h2b, 8'h01);
      nxt.noise = 8'hff;
      step(8'h01);
      chk({alert_n, touch_report[0]}, 8'h03);
      nxt.base_out = 8'h81;
      step(8'h00);
      rd(8'h2e, 8'h81);
      rd(touch_block_pkg::ADDR_STATUS, 8'h04);
      finish_test();
   end
endmodule
